// *** mmru_map.svh ***
// constant map for the modbus master request unpacker
`ifndef MMRU_MAP_SVH
`define MMRU_MAP_SVH
`define MMRU_FC_RD_COILS 8'h01
`define MMRU_FC_RD_INPUTS 8'h02
`define MMRU_FC_RD_HOLDING 8'h03
`define MMRU_FC_RD_INREGS 8'h04
`define MMRU_FC_WR_COIL 8'h05
`define MMRU_FC_WR_REG 8'h06
`define MMRU_FC_EXC_STATUS 8'h07
`define MMRU_FC_LOOPBACK 8'h08
`define MMRU_FC_EV_COUNTER 8'h0B
`define MMRU_FC_EV_LOG 8'h0C
`define MMRU_FC_WR_COILS 8'h0F
`define MMRU_FC_WR_REGS 8'h10
`define MMRU_FC_ERR_BIT 7
`define MMRU_FC_WIDE_BIT 6
`define MMRU_FC_WIDE_MASK 8'hBF
`define MMRU_CRC_INIT 16'hFFFF
`define MMRU_LRC_INIT 16'h0000
`define MMRU_CRC_POLY 16'hA001
`define MMRU_CHK_LEN_RTU 10'h002
`define MMRU_CHK_LEN_ASCII 10'h001
`define MMRU_HDR_SHORT 10'h002
`define MMRU_HDR_FIELDS 10'h006
`define MMRU_HDR_BLOCK 10'h007
`define MMRU_TX_STATION 10'h000
`define MMRU_TX_OPCODE 10'h001
`define MMRU_TX_W2_HI 10'h002
`define MMRU_TX_W2_LO 10'h003
`define MMRU_TX_W4_HI 10'h004
`define MMRU_TX_W4_LO 10'h005
`define MMRU_TX_COUNT 10'h006
`define MMRU_COIL_ROUND 16'h0007
`define MMRU_REC_PAY_WORD 8'h03
`define MMRU_RX_STATION 8'h00
`define MMRU_RX_OPCODE 8'h01
`define MMRU_RX_COUNT 8'h02
`define MMRU_RX_DATA 8'h03
`define MMRU_RX_MIN 9'h004
`define MMRU_RX_STORE_MAX 9'h1FF
`define MMRU_EVCNT_WORDS 8'h02
`define MMRU_EVLOG_WORDS 8'h23
`endif

// *** mmru_pkg.sv ***
// types for the modbus master request unpacker
package mmru_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEND = 3'b001,
        ST_WAIT = 3'b010,
        ST_CHECK = 3'b011,
        ST_COPY = 3'b100
    } mmru_state_t;
    typedef enum logic [1:0] {
        RES_OK = 2'b00,
        RES_EXC = 2'b01,
        RES_BAD = 2'b10
    } mmru_result_t;
    typedef enum logic [1:0] {
        CP_NONE = 2'b00,
        CP_BITS = 2'b01,
        CP_WORDS = 2'b10,
        CP_HIGH = 2'b11
    } mmru_copy_t;
endpackage : mmru_pkg

// *** mmru_unpacker.sv ***
// modbus master: builds requests from a record, unpacks replies into a word buffer
// Behaviour
// RULE_01 - bit replies fill low bytes word-wise
// RULE_02 - unused high byte of last word zero
// RULE_03 - function 03 request from record fields
// RULE_04 - user keeps register count within limits
// RULE_05 - start, bit index, coil value sent unchanged
// RULE_06 - function 04 same layout, words stored
// RULE_07 - user gives coil code 0000h or FF00h
// RULE_08 - function 06 writes any word value
// RULE_09 - exception status into high byte only
// RULE_10 - user sets loopback subfunction to zero
// RULE_11 - slave echoes loopback request exactly
// RULE_12 - loopback reply checked, never stored
// RULE_13 - function 11 stores status and counter
// RULE_14 - function 12 stores three words, 64 bytes
// RULE_15 - user gives coil count, packed words
// RULE_16 - user gives register count, data words
// RULE_17 - slave error reply sets function bit 7
// RULE_18 - ascii 32-bit mode uses function bit 6
// RULE_19 - frame check appended, bad replies dropped
`timescale 1ns/1ps
`include "mmru_map.svh"
module mmru_unpacker
    import mmru_pkg::*;
(
    // clock, reset, enable, framing options
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic asciiMode,
    input wire logic reg32Enable,
    // request record
    input wire logic reqStart,
    input wire logic [7:0] stationId,
    input wire logic [7:0] opCode,
    input wire logic [15:0] recWord2,
    input wire logic [15:0] recWord4,
    output logic [7:0] reqDataIdx,
    input wire logic [15:0] reqDataWord,
    // request byte stream
    output logic [7:0] txData,
    output logic txValid,
    output logic txLast,
    input wire logic txReady,
    // reply byte stream
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    input wire logic rxEnd,
    // reply buffer write port
    output logic bufWrEn,
    output logic [6:0] bufWrAddr,
    output logic [15:0] bufWrData,
    output logic [1:0] bufWrByteEn,
    // status
    output logic busy,
    output logic done,
    output mmru_result_t result,
    output logic [7:0] exceptionCode
);
    mmru_state_t state, next_state;
    mmru_copy_t cpMode, next_cpMode;
    mmru_result_t next_result;
    logic [7:0] station, next_station, opSent, next_opSent;
    logic [15:0] rec2, next_rec2, rec4, next_rec4;
    logic wide, next_wide, asciiL, next_asciiL;
    logic [9:0] txIdx, next_txIdx;
    logic [15:0] crc, next_crc, rxCrc, next_rxCrc;
    logic [7:0] next_txData, next_exceptionCode;
    logic next_txValid, next_txLast, next_bufWrEn, next_done;
    logic [6:0] next_bufWrAddr;
    logic [15:0] next_bufWrData;
    logic [1:0] next_bufWrByteEn;
    logic [8:0] rxCnt, next_rxCnt;
    logic [7:0] cpBase, next_cpBase, cpWords, next_cpWords, cpBytes, next_cpBytes;
    logic [7:0] wrIdx, next_wrIdx;
    // a full-length read reply runs past 256 bytes, so the store is deeper than a byte index
    logic [7:0] rxMem [0:511];
    logic memWe, wideReq, frameOk, loopOk, isExc;
    logic [9:0] hdrLen, payLen, bodyLen, totLen, payIdx;
    logic [15:0] coilSum;
    logic [7:0] txByte, payByte;

    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b,
                                            input logic lrc);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MMRU_CRC_POLY) : (r >> 1);
        end
        if (lrc) begin
            r = {8'h00, 8'(c[7:0] + b)};
        end
        return r;
    endfunction : crcStep

    function automatic logic [8:0] pick(input logic [7:0] base, input logic [7:0] w,
                                        input logic odd);
        return {1'b0, base} + {1'b0, w[6:0], 1'b0} + {8'h00, odd};
    endfunction : pick

    // functions 03, 06 and 10 with bit 6 set are wide accesses in ascii framing with reg32Enable set
    assign wideReq = asciiMode && reg32Enable && opCode[`MMRU_FC_WIDE_BIT] && // RULE_18
        ((opCode & `MMRU_FC_WIDE_MASK) == `MMRU_FC_RD_HOLDING ||
         (opCode & `MMRU_FC_WIDE_MASK) == `MMRU_FC_WR_REG ||
         (opCode & `MMRU_FC_WIDE_MASK) == `MMRU_FC_WR_REGS);
    assign busy = (state != ST_IDLE);

    // request length and byte selection
    always_comb begin
        coilSum = rec4 + `MMRU_COIL_ROUND;
        unique case (opSent)
            `MMRU_FC_EXC_STATUS, `MMRU_FC_EV_COUNTER, `MMRU_FC_EV_LOG: hdrLen = `MMRU_HDR_SHORT;
            `MMRU_FC_WR_COILS, `MMRU_FC_WR_REGS: hdrLen = `MMRU_HDR_BLOCK;
            default: hdrLen = `MMRU_HDR_FIELDS;
        endcase
        if (opSent == `MMRU_FC_WR_COILS) begin
            payLen = coilSum[12:3];
        end else if (opSent == `MMRU_FC_WR_REGS) begin
            payLen = wide ? {rec4[7:0], 2'b00} : {1'b0, rec4[7:0], 1'b0};
        end else begin
            payLen = 10'h000;
        end
        bodyLen = hdrLen + payLen;
        totLen = bodyLen + (asciiL ? `MMRU_CHK_LEN_ASCII : `MMRU_CHK_LEN_RTU); // RULE_19
        payIdx = txIdx - `MMRU_HDR_BLOCK;
        // coil words go low byte first, register words high byte first
        if (opSent == `MMRU_FC_WR_COILS) begin
            payByte = payIdx[0] ? reqDataWord[15:8] : reqDataWord[7:0];
        end else begin
            payByte = payIdx[0] ? reqDataWord[7:0] : reqDataWord[15:8];
        end
        if (txIdx >= bodyLen) begin
            if (asciiL) begin
                txByte = 8'h00 - crc[7:0]; // RULE_19
            end else begin
                txByte = (txIdx == bodyLen) ? crc[7:0] : crc[15:8]; // RULE_19
            end
        end else begin
            unique case (txIdx)
                `MMRU_TX_STATION: txByte = station; // RULE_03
                `MMRU_TX_OPCODE: txByte = opSent; // RULE_03
                `MMRU_TX_W2_HI: txByte = rec2[15:8]; // RULE_05
                `MMRU_TX_W2_LO: txByte = rec2[7:0]; // RULE_05
                `MMRU_TX_W4_HI: txByte = rec4[15:8]; // RULE_08
                `MMRU_TX_W4_LO: txByte = rec4[7:0]; // RULE_08
                `MMRU_TX_COUNT: txByte = payLen[7:0];
                default: txByte = payByte;
            endcase
        end
    end
    assign reqDataIdx = `MMRU_REC_PAY_WORD + payIdx[8:1];

    // reply screening
    always_comb begin
        isExc = rxMem[`MMRU_RX_OPCODE][`MMRU_FC_ERR_BIT];
        loopOk = (opSent != `MMRU_FC_LOOPBACK) || // RULE_12
            ({rxMem[`MMRU_RX_COUNT], rxMem[`MMRU_RX_DATA]} == rec2 &&
             {rxMem[4], rxMem[5]} == rec4);
        frameOk = (asciiL ? (rxCrc[7:0] == 8'h00) : (rxCrc == 16'h0000)) && // RULE_19
            rxCnt >= `MMRU_RX_MIN && rxMem[`MMRU_RX_STATION] == station &&
            rxMem[`MMRU_RX_OPCODE][6:0] == opSent[6:0] && (isExc || loopOk);
    end

    always_comb begin
        next_state = state;
        next_station = station;
        next_opSent = opSent;
        next_rec2 = rec2;
        next_rec4 = rec4;
        next_wide = wide;
        next_asciiL = asciiL;
        next_txIdx = txIdx;
        next_crc = crc;
        next_txData = txData;
        next_txValid = txValid;
        next_txLast = txLast;
        next_rxCnt = rxCnt;
        next_rxCrc = rxCrc;
        next_cpMode = cpMode;
        next_cpBase = cpBase;
        next_cpWords = cpWords;
        next_cpBytes = cpBytes;
        next_wrIdx = wrIdx;
        next_bufWrEn = 1'b0;
        next_bufWrAddr = bufWrAddr;
        next_bufWrData = bufWrData;
        next_bufWrByteEn = bufWrByteEn;
        next_done = 1'b0;
        next_result = result;
        next_exceptionCode = exceptionCode;
        memWe = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (reqStart) begin
                    next_station = stationId;
                    next_wide = wideReq; // RULE_18
                    next_opSent = wideReq ? (opCode & `MMRU_FC_WIDE_MASK) : opCode; // RULE_18
                    next_rec2 = recWord2; // RULE_05
                    next_rec4 = recWord4; // RULE_05
                    next_asciiL = asciiMode;
                    next_crc = asciiMode ? `MMRU_LRC_INIT : `MMRU_CRC_INIT;
                    next_txIdx = 10'h000;
                    next_state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (!txValid || txReady) begin
                    if (txIdx < totLen) begin
                        next_txData = txByte;
                        next_txValid = 1'b1;
                        next_txLast = (txIdx + 10'h001 == totLen);
                        next_txIdx = txIdx + 10'h001;
                        if (txIdx < bodyLen) begin
                            next_crc = crcStep(crc, txByte, asciiL); // RULE_19
                        end
                    end else begin
                        next_txValid = 1'b0;
                        next_txLast = 1'b0;
                        next_rxCnt = 9'h000;
                        next_rxCrc = asciiL ? `MMRU_LRC_INIT : `MMRU_CRC_INIT;
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                // the store covers the longest legal reply; a runaway frame stops filling it
                if (rxValid && rxCnt != `MMRU_RX_STORE_MAX) begin
                    memWe = 1'b1;
                    next_rxCnt = rxCnt + 9'h001;
                    next_rxCrc = crcStep(rxCrc, rxData, asciiL);
                end
                if (rxEnd) begin
                    next_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                next_wrIdx = 8'h00;
                next_cpBase = `MMRU_RX_DATA;
                next_cpBytes = rxMem[`MMRU_RX_COUNT];
                next_cpWords = 8'h00;
                next_cpMode = CP_NONE;
                unique case (opSent)
                    `MMRU_FC_RD_COILS, `MMRU_FC_RD_INPUTS: begin
                        next_cpMode = CP_BITS; // RULE_01
                        next_cpWords = 8'({1'b0, rxMem[`MMRU_RX_COUNT]} + 9'h001 >> 1);
                    end
                    `MMRU_FC_RD_HOLDING, `MMRU_FC_RD_INREGS: begin
                        next_cpMode = CP_WORDS; // RULE_06
                        next_cpWords = rxMem[`MMRU_RX_COUNT] >> 1;
                    end
                    `MMRU_FC_EV_LOG: begin
                        next_cpMode = CP_WORDS; // RULE_14
                        next_cpWords = `MMRU_EVLOG_WORDS;
                    end
                    `MMRU_FC_EV_COUNTER: begin
                        next_cpMode = CP_WORDS; // RULE_13
                        next_cpBase = `MMRU_RX_COUNT;
                        next_cpWords = `MMRU_EVCNT_WORDS;
                    end
                    `MMRU_FC_EXC_STATUS: begin
                        next_cpMode = CP_HIGH; // RULE_09
                        next_cpBase = `MMRU_RX_COUNT;
                        next_cpWords = 8'h01;
                    end
                    default: begin
                    end
                endcase
                if (!frameOk) begin
                    next_result = RES_BAD; // RULE_19
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                end else if (isExc) begin
                    next_result = RES_EXC;
                    next_exceptionCode = rxMem[`MMRU_RX_COUNT];
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                end else if (next_cpMode == CP_NONE || next_cpWords == 8'h00) begin
                    next_result = RES_OK; // RULE_12
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_COPY;
                end
            end
            ST_COPY: begin
                next_bufWrEn = 1'b1;
                next_bufWrAddr = wrIdx[6:0];
                next_bufWrByteEn = 2'b11;
                unique case (cpMode)
                    CP_BITS: begin
                        next_bufWrData[7:0] = rxMem[pick(cpBase, wrIdx, 1'b0)]; // RULE_01
                        next_bufWrData[15:8] = ({wrIdx[6:0], 1'b1} < cpBytes) ?
                            rxMem[pick(cpBase, wrIdx, 1'b1)] : 8'h00; // RULE_02
                    end
                    CP_HIGH: begin
                        next_bufWrData = {rxMem[cpBase], 8'h00};
                        next_bufWrByteEn = 2'b10; // RULE_09
                    end
                    default: begin
                        next_bufWrData = {rxMem[pick(cpBase, wrIdx, 1'b0)],
                                          rxMem[pick(cpBase, wrIdx, 1'b1)]}; // RULE_06
                    end
                endcase
                next_wrIdx = wrIdx + 8'h01;
                if (wrIdx + 8'h01 >= cpWords) begin
                    next_result = RES_OK;
                    next_done = 1'b1;
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            station <= 8'h00;
            opSent <= 8'h00;
            rec2 <= 16'h0000;
            rec4 <= 16'h0000;
            wide <= 1'b0;
            asciiL <= 1'b0;
            txIdx <= 10'h000;
            crc <= `MMRU_CRC_INIT;
            txData <= 8'h00;
            txValid <= 1'b0;
            txLast <= 1'b0;
            rxCnt <= 9'h000;
            rxCrc <= `MMRU_CRC_INIT;
            cpMode <= CP_NONE;
            cpBase <= 8'h00;
            cpWords <= 8'h00;
            cpBytes <= 8'h00;
            wrIdx <= 8'h00;
            bufWrEn <= 1'b0;
            bufWrAddr <= 7'h00;
            bufWrData <= 16'h0000;
            bufWrByteEn <= 2'b00;
            done <= 1'b0;
            result <= RES_OK;
            exceptionCode <= 8'h00;
        end else if (ce) begin
            state <= next_state;
            station <= next_station;
            opSent <= next_opSent;
            rec2 <= next_rec2;
            rec4 <= next_rec4;
            wide <= next_wide;
            asciiL <= next_asciiL;
            txIdx <= next_txIdx;
            crc <= next_crc;
            txData <= next_txData;
            txValid <= next_txValid;
            txLast <= next_txLast;
            rxCnt <= next_rxCnt;
            rxCrc <= next_rxCrc;
            cpMode <= next_cpMode;
            cpBase <= next_cpBase;
            cpWords <= next_cpWords;
            cpBytes <= next_cpBytes;
            wrIdx <= next_wrIdx;
            bufWrEn <= next_bufWrEn;
            bufWrAddr <= next_bufWrAddr;
            bufWrData <= next_bufWrData;
            bufWrByteEn <= next_bufWrByteEn;
            done <= next_done;
            result <= next_result;
            exceptionCode <= next_exceptionCode;
        end
    end

    // reply store is held whole until the frame check decides
    always_ff @(posedge core_clk) begin
        if (ce && memWe) begin
            rxMem[rxCnt] <= rxData;
        end
    end

    default clocking cb @(posedge core_clk iff ce); endclocking
    default disable iff (srst);

    sequence s_badEnd;
        state == ST_CHECK && !frameOk;
    endsequence
    sequence s_reportBad;
        done && result == RES_BAD && !bufWrEn;
    endsequence

    property p_bitLow;
        bufWrEn && cpMode == CP_BITS |->
            bufWrData[7:0] == rxMem[pick(cpBase, {1'b0, bufWrAddr}, 1'b0)];
    endproperty
    a_bitLow: assert property (p_bitLow) else $error("bit reply low byte wrong"); // RULE_01
    property p_bitPad;
        bufWrEn && cpMode == CP_BITS && {bufWrAddr, 1'b1} >= cpBytes |-> bufWrData[15:8] == 8'h00;
    endproperty
    a_bitPad: assert property (p_bitPad) else $error("unused high byte not zero"); // RULE_02
    property p_hdr;
        txValid && txIdx == 10'h002 |-> txData == opSent;
    endproperty
    a_hdr: assert property (p_hdr) else $error("operation code byte wrong"); // RULE_03
    property p_passThru;
        txValid && txIdx == 10'h004 && hdrLen != `MMRU_HDR_SHORT |-> txData == rec2[7:0];
    endproperty
    a_passThru: assert property (p_passThru) else $error("start index altered"); // RULE_05
    property p_regWord;
        bufWrEn && cpMode == CP_WORDS |-> bufWrData ==
            {rxMem[pick(cpBase, {1'b0, bufWrAddr}, 1'b0)],
             rxMem[pick(cpBase, {1'b0, bufWrAddr}, 1'b1)]};
    endproperty
    a_regWord: assert property (p_regWord) else $error("register word misplaced"); // RULE_06
    property p_single;
        txValid && txLast && opSent == `MMRU_FC_WR_REG && !asciiL |-> txIdx == 10'h008;
    endproperty
    a_single: assert property (p_single) else $error("single write length wrong"); // RULE_08
    property p_excHigh;
        bufWrEn && opSent == `MMRU_FC_EXC_STATUS |-> bufWrByteEn == 2'b10 && bufWrAddr == 7'h00;
    endproperty
    a_excHigh: assert property (p_excHigh) else $error("event bits not high only"); // RULE_09
    property p_loopQuiet;
        opSent == `MMRU_FC_LOOPBACK |-> !bufWrEn;
    endproperty
    a_loopQuiet: assert property (p_loopQuiet) else $error("loopback reply stored"); // RULE_12
    property p_evCnt;
        bufWrEn && opSent == `MMRU_FC_EV_COUNTER && bufWrAddr == 7'h00 |=>
            bufWrEn && bufWrAddr == 7'h01 && done;
    endproperty
    a_evCnt: assert property (p_evCnt) else $error("counter words wrong"); // RULE_13
    property p_evLog;
        done && result == RES_OK && opSent == `MMRU_FC_EV_LOG |-> bufWrEn && bufWrAddr == 7'h22;
    endproperty
    a_evLog: assert property (p_evLog) else $error("event log length wrong"); // RULE_14
    property p_wide;
        state == ST_IDLE && reqStart && wideReq |=> wide && !opSent[`MMRU_FC_WIDE_BIT];
    endproperty
    a_wide: assert property (p_wide) else $error("wide access not taken"); // RULE_18
    property p_check;
        s_badEnd |=> s_reportBad;
    endproperty
    a_check: assert property (p_check) else $error("bad reply not dropped"); // RULE_19
    property p_crcTail;
        txValid && txLast && !asciiL |-> txData == crc[15:8];
    endproperty
    a_crcTail: assert property (p_crcTail) else $error("frame check byte wrong"); // RULE_19
endmodule : mmru_unpacker

// *** mmru_slave.sv ***
// remote slave station model: echoes loopback requests, otherwise replies with a queued frame
`timescale 1ns/1ps
module mmru_slave (
    // clock
    input wire logic core_clk,
    // request stream from the master
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic txLast,
    output logic txReady,
    // reply stream to the master
    output logic [7:0] rxData,
    output logic rxValid,
    output logic rxEnd
);
    logic [7:0] req[$];
    logic [7:0] rsp[$];
    logic badCrc = 1'b0;
    logic lrc = 1'b0;
    event reqDone;
    // with lrc set the check is the two's complement of the byte sum, one byte long
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c;
        logic [7:0] s;
        c = 16'hFFFF;
        s = 8'h00;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            s += q[i];
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return lrc ? {8'h00, 8'h00 - s} : c;
    endfunction : crc
    initial begin
        txReady = 1'b0;
        rxData = 8'h00;
        rxValid = 1'b0;
        rxEnd = 1'b0;
    end
    // random stalls so the master has to hold its byte
    always @(negedge core_clk) txReady <= $urandom_range(3) != 0;
    always @(posedge core_clk) if (txValid && txReady) begin
        req.push_back(txData);
        if (txLast) -> reqDone;
    end
    always @(reqDone) begin : reply
        logic [7:0] f[$];
        logic [15:0] c;
        f = rsp;
        c = crc(f) ^ {15'h0000, badCrc};
        f.push_back(c[7:0]);
        if (!lrc) f.push_back(c[15:8]);
        if (req[1] == 8'h08) f = req;
        repeat (3) @(negedge core_clk);
        foreach (f[i]) begin
            rxData <= f[i];
            rxValid <= 1'b1;
            rxEnd <= i == f.size() - 1;
            @(negedge core_clk);
        end
        // released line shows the inverse, not a stale byte
        rxData <= ~rxData;
        rxValid <= 1'b0;
        rxEnd <= 1'b0;
    end
endmodule : mmru_slave

// *** modbus_master_request_unpacker_test.sv ***
// self-checking bench: request bytes, reply writes and result against a queue model
`timescale 1ns/1ps
module modbus_master_request_unpacker_test;
    import mmru_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic asciiMode = 1'b0;
    logic reg32Enable = 1'b0;
    logic reqStart = 1'b0;
    logic [7:0] stationId = 8'h00;
    logic [7:0] opCode = 8'h00;
    logic [15:0] recWord2 = 16'h0000;
    logic [15:0] recWord4 = 16'h0000;
    logic [15:0] rec [0:7];
    logic [7:0] reqDataIdx, txData, rxData, exceptionCode;
    logic txValid, txLast, txReady, rxValid, rxEnd, bufWrEn, busy, done;
    logic [6:0] bufWrAddr;
    logic [15:0] bufWrData;
    logic [1:0] bufWrByteEn;
    mmru_result_t result;
    logic [24:0] wq[$];
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    always #10 core_clk = ~core_clk;
    mmru_unpacker dut_u (.core_clk(core_clk), .srst(srst), .ce(1'b1), .asciiMode(asciiMode),
        .reg32Enable(reg32Enable), .reqStart(reqStart), .stationId(stationId), .opCode(opCode),
        .recWord2(recWord2), .recWord4(recWord4), .reqDataIdx(reqDataIdx),
        .reqDataWord(rec[reqDataIdx[2:0]]), .txData(txData), .txValid(txValid),
        .txLast(txLast), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
        .rxEnd(rxEnd), .bufWrEn(bufWrEn), .bufWrAddr(bufWrAddr), .bufWrData(bufWrData),
        .bufWrByteEn(bufWrByteEn), .busy(busy), .done(done), .result(result),
        .exceptionCode(exceptionCode));
    mmru_slave slave_u (.core_clk(core_clk), .txData(txData), .txValid(txValid),
        .txLast(txLast), .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .rxEnd(rxEnd));
    // unwritten byte lanes are masked so only enabled bytes are compared
    always @(negedge core_clk) if (bufWrEn === 1'b1)
        wq.push_back({bufWrAddr, bufWrByteEn,
            bufWrData & {{8{bufWrByteEn[1]}}, {8{bufWrByteEn[0]}}}});
    always @(posedge core_clk) if (++cycles == 60000) begin
        failures++;
        tally_and_finish();
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic run(input logic [7:0] code, input int n, input logic [15:0] w4, input int mode);
        logic [7:0] op, st, rsp[$], tx[$];
        logic [15:0] c;
        logic [24:0] ew[$];
        int s, k;
        // wide register codes go out with bit 6 cleared
        op = (asciiMode && reg32Enable && code inside {8'h43, 8'h46, 8'h50}) ?
            code & 8'hBF : code;
        slave_u.lrc = asciiMode;
        st = $urandom;
        recWord2 = (op == 8'h08) ? 16'h0000 : 16'($urandom);
        tx = {st, op};
        if (!(op inside {8'h07, 8'h0B, 8'h0C}))
            tx = {tx, recWord2[15:8], recWord2[7:0], w4[15:8], w4[7:0]};
        if (op == 8'h0F) tx = {tx, 8'h02, rec[3][7:0], rec[3][15:8]};
        if (op == 8'h10) tx = {tx, 8'h04, rec[3][15:8], rec[3][7:0], rec[4][15:8], rec[4][7:0]};
        c = slave_u.crc(tx);
        tx.push_back(c[7:0]);
        if (!asciiMode) tx.push_back(c[15:8]);
        rsp = {st, op};
        if (op inside {8'h05, 8'h06, 8'h0F, 8'h10}) rsp = {rsp, tx[2:5]};
        else if (!(op inside {8'h07, 8'h0B})) rsp.push_back(n[7:0]);
        s = rsp.size();
        repeat (op inside {8'h05, 8'h06, 8'h08, 8'h0F, 8'h10} ? 0 : n) rsp.push_back($urandom);
        k = (op < 8'h03) ? (n + 1) / 2 : (op inside {8'h03, 8'h04, 8'h0B, 8'h0C}) ? n / 2 : 0;
        for (int w = 0; w < k; w++)
            ew.push_back(op < 8'h03 ? {w[6:0], 2'b11,
                (s + 2 * w + 1 < rsp.size()) ? rsp[s + 2 * w + 1] : 8'h00, rsp[s + 2 * w]}
                : {w[6:0], 2'b11, rsp[s + 2 * w], rsp[s + 2 * w + 1]});
        if (op == 8'h07) ew = {{7'h00, 2'b10, rsp[2], 8'h00}};
        if (mode != 0) ew.delete();
        if (mode == 1) rsp = {st, op | 8'h80, 8'h02};
        slave_u.rsp = rsp;
        slave_u.badCrc = mode == 2;
        slave_u.req.delete();
        wq.delete();
        stationId = st;
        opCode = code;
        recWord4 = w4;
        reqStart = 1'b1;
        @(negedge core_clk);
        reqStart = 1'b0;
        do @(negedge core_clk); while (done !== 1'b1);
        @(negedge core_clk);
        check("result", result, mode);
        if (mode == 1) check("exception code", exceptionCode, 8'h02);
        check("request length", slave_u.req.size(), tx.size());
        foreach (tx[i]) check("request byte", slave_u.req[i], tx[i]);
        check("write count", wq.size(), ew.size());
        foreach (ew[i]) check("reply word", wq[i], ew[i]);
        $display("test op %0h mode %0d finished", op, mode);
    endtask : run
    initial begin
        void'($urandom(32'h72E6E2C5));
        foreach (rec[i]) rec[i] = $urandom;
        repeat (20) @(negedge core_clk);
        srst = 1'b0;
        check("idle after reset", {busy, txValid, done}, 3'b000);
        run(8'h01, 3, 16'h0011, 0);
        run(8'h02, 1, 16'h0005, 0);
        run(8'h03, 6, 16'h0003, 0);
        run(8'h04, 254, 16'h007F, 0);
        run(8'h05, 0, 16'hFF00, 0);
        run(8'h05, 0, 16'h0000, 0);
        run(8'h06, 0, 16'hA5C3, 0);
        run(8'h07, 1, 16'h0000, 0);
        run(8'h08, 0, 16'h1234, 0);
        run(8'h0B, 4, 16'h0000, 0);
        run(8'h0C, 70, 16'h0000, 0);
        run(8'h0F, 0, 16'h0009, 0);
        run(8'h10, 0, 16'h0002, 0);
        run(8'h03, 2, 16'h0001, 1);
        run(8'h04, 2, 16'h0001, 2);
        asciiMode = 1'b1;
        reg32Enable = 1'b1;
        run(8'h43, 8, 16'h0002, 0);
        run(8'h0B, 4, 16'h0000, 2);
        tally_and_finish();
    end
endmodule : modbus_master_request_unpacker_test
